// ===== logic/ssi_pkg.sv
// constants for the serial status and interrupt block
package ssi_pkg;
	// register indices; byte address is index times four
	localparam logic [7:0] SSI_IDX_RX_SYNC_DATA = 8'h00;
	localparam logic [7:0] SSI_IDX_TX_SYNC_DATA = 8'h01;
	localparam logic [7:0] SSI_IDX_STATUS = 8'h02;
	localparam logic [7:0] SSI_IDX_IRQ_SET = 8'h03;
	localparam logic [7:0] SSI_IDX_IRQ_CLR = 8'h04;
	localparam logic [7:0] SSI_IDX_IRQ_MASK = 8'h05;
	localparam logic [7:0] SSI_IDX_CTRL = 8'h06;
	// status / mask bit positions
	localparam int SSI_B_TX_HOLDING_FREE = 0;
	localparam int SSI_B_TX_ALL_SENT = 1;
	localparam int SSI_B_TX_COUNT_DONE = 2;
	localparam int SSI_B_TX_COUNTERS_ZERO = 3;
	localparam int SSI_B_RX_WORD_AVAILABLE = 4;
	localparam int SSI_B_RX_OVERFLOW = 5;
	localparam int SSI_B_RX_COUNT_DONE = 6;
	localparam int SSI_B_RX_COUNTERS_ZERO = 7;
	localparam int SSI_B_TX_FRAME_SYNC_SEEN = 10;
	localparam int SSI_B_RX_FRAME_SYNC_SEEN = 11;
	localparam int SSI_B_TRANSMITTER_ON = 16;
	localparam int SSI_B_RECEIVER_ON = 17;
	// bits that can interrupt
	localparam logic [31:0] SSI_IRQ_BITS = 32'h0000_0cff;
	// control register fields
	localparam int SSI_C_EDGE = 0;
	localparam int SSI_C_SDEN = 1;
	localparam int SSI_C_LEN_LO = 4;
	localparam int SSI_SYNC_W = 16;
	localparam logic [31:0] SSI_RESET_ZERO = 32'h0000_0000;
endpackage : ssi_pkg

// ===== logic/ssi_status_irq.sv
// status, interrupt mask and frame sync data registers of the serial controller
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - sync data registers hold 16 bits, right aligned, upper bits read zero
// - status bit 0 high when transmit holding register empty
// - status bit 1 high once all written data loaded and shifted out
// - bit 2 set when tx counter reaches zero; counter writes clear it
// - bit 3 high only when both tx counters are zero
// - bit 4 high when a received word sits in the holding register
// - bit 5 set on load over unread word; cleared by status read
// - bit 6 set when rx counter reaches zero; counter writes clear it
// - bit 7 high only when both rx counters are zero
// - bit 10 set on transmit frame sync; status read clears it
// - bit 11 set on receive frame sync; status read clears it
// - bits 16 and 17 show transmitter and receiver enabled
// - writing one to enable register sets matching mask bit if that bit can interrupt
// - writing one to disable register clears matching mask bit
// - mask register reads enabled sources; writes ignored
// - edge select bit: zero rising, one falling edge sets tx sync flag
// - with sync data on, shift tx sync word out during frame sync
module ssi_status_irq
	import ssi_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// state from the shift engines and transfer engine, same clock
	input wire logic tx_holding_full_i,
	input wire logic tx_shifting_i,
	input wire logic tx_count_zero_i,
	input wire logic tx_next_count_zero_i,
	input wire logic tx_count_write_i,
	input wire logic rx_holding_load_i,
	input wire logic rx_holding_read_i,
	input wire logic rx_count_zero_i,
	input wire logic rx_next_count_zero_i,
	input wire logic rx_count_write_i,
	input wire logic rx_sync_event_i,
	input wire logic transmitter_on_i,
	input wire logic receiver_on_i,
	// link pins, outside this clock domain
	input wire logic tx_clk_i,
	input wire logic tx_frame_sync_i,
	// sync data output
	output logic tx_sync_data_o,
	output logic tx_sync_data_oe_o,
	// interrupt
	output logic irq_o
);
	// register file
	logic [SSI_SYNC_W-1:0] rx_sync_word_ff;
	logic [SSI_SYNC_W-1:0] tx_sync_word_ff;
	logic [31:0] mask_ff;
	logic [31:0] rdata_ff;
	logic [7:0] ctrl_ff;
	// event flags
	logic tx_count_done_ff;
	logic rx_count_done_ff;
	logic rx_overflow_ff;
	logic rx_word_available_ff;
	logic tx_fs_seen_ff;
	logic rx_fs_seen_ff;
	// last seen counter state, for the reach-zero edge
	logic tx_zero_q_ff;
	logic rx_zero_q_ff;
	// link pin synchronisers and edge history
	logic [1:0] fs_sync_ff;
	logic [1:0] ck_sync_ff;
	logic fs_prev_ff;
	logic ck_prev_ff;
	// sync word shifter
	logic [4:0] bit_cnt_ff;
	logic sd_ff;
	logic sd_oe_ff;

	// register decodes, one strobe at a time from the bus
	wire logic wr_rx_sd = reg_wr_i && reg_addr_i == SSI_IDX_RX_SYNC_DATA;
	wire logic wr_tx_sd = reg_wr_i && reg_addr_i == SSI_IDX_TX_SYNC_DATA;
	wire logic wr_set = reg_wr_i && reg_addr_i == SSI_IDX_IRQ_SET;
	wire logic wr_clr = reg_wr_i && reg_addr_i == SSI_IDX_IRQ_CLR;
	wire logic wr_ctrl = reg_wr_i && reg_addr_i == SSI_IDX_CTRL;
	wire logic rd_stat = reg_rd_i && reg_addr_i == SSI_IDX_STATUS;

	// synchronised link pins
	wire logic fs_s = fs_sync_ff[1];
	wire logic ck_s = ck_sync_ff[1];
	wire logic fs_rise = fs_s && !fs_prev_ff;
	wire logic fs_fall = !fs_s && fs_prev_ff;
	wire logic tx_fs_evt = ctrl_ff[SSI_C_EDGE] ? fs_fall : fs_rise;
	wire logic ck_fall = !ck_s && ck_prev_ff;

	// control fields
	wire logic sd_en = ctrl_ff[SSI_C_SDEN];
	wire logic [3:0] sync_length = ctrl_ff[SSI_C_LEN_LO +: 4];

	// status bits that follow the engines directly
	wire logic tx_holding_free = !tx_holding_full_i;
	wire logic tx_all_sent = !tx_holding_full_i && !tx_shifting_i;
	wire logic tx_counters_zero = tx_count_zero_i && tx_next_count_zero_i;
	wire logic rx_counters_zero = rx_count_zero_i && rx_next_count_zero_i;

	logic [31:0] status;
	always_comb begin
		status = SSI_RESET_ZERO;
		// transmit side
		status[SSI_B_TX_HOLDING_FREE] = tx_holding_free;
		status[SSI_B_TX_ALL_SENT] = tx_all_sent;
		status[SSI_B_TX_COUNT_DONE] = tx_count_done_ff;
		status[SSI_B_TX_COUNTERS_ZERO] = tx_counters_zero;
		// receive side
		status[SSI_B_RX_WORD_AVAILABLE] = rx_word_available_ff;
		status[SSI_B_RX_OVERFLOW] = rx_overflow_ff;
		status[SSI_B_RX_COUNT_DONE] = rx_count_done_ff;
		status[SSI_B_RX_COUNTERS_ZERO] = rx_counters_zero;
		// frame sync events and engine enables
		status[SSI_B_TX_FRAME_SYNC_SEEN] = tx_fs_seen_ff;
		status[SSI_B_RX_FRAME_SYNC_SEEN] = rx_fs_seen_ff;
		status[SSI_B_TRANSMITTER_ON] = transmitter_on_i;
		status[SSI_B_RECEIVER_ON] = receiver_on_i;
	end

	// read views; reserved upper bits read zero
	wire logic [31:0] rx_sync_view = {16'h0000, rx_sync_word_ff};
	wire logic [31:0] tx_sync_view = {16'h0000, tx_sync_word_ff};
	wire logic [31:0] ctrl_view = {24'h000000, ctrl_ff};

	// unmapped and write-only indices read zero
	logic [31:0] rd_mux;
	always_comb begin
		unique case (reg_addr_i)
			SSI_IDX_RX_SYNC_DATA: rd_mux = rx_sync_view;
			SSI_IDX_TX_SYNC_DATA: rd_mux = tx_sync_view;
			SSI_IDX_STATUS: rd_mux = status;
			SSI_IDX_IRQ_MASK: rd_mux = mask_ff;
			SSI_IDX_CTRL: rd_mux = ctrl_view;
			default: rd_mux = SSI_RESET_ZERO;
		endcase
	end

	// read data stand one cycle only, zero otherwise
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_ff <= SSI_RESET_ZERO;
		end else if (reg_rd_i) begin
			rdata_ff <= rd_mux;
		end else begin
			rdata_ff <= SSI_RESET_ZERO;
		end
	end

	// receive sync word; only the low half is kept
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_sync_word_ff <= 16'h0000;
		end else if (wr_rx_sd) begin
			rx_sync_word_ff <= reg_wdata_i[SSI_SYNC_W-1:0];
		end
	end

	// transmit sync word; a write during a frame shows up from the next bit on
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_sync_word_ff <= 16'h0000;
		end else if (wr_tx_sd) begin
			tx_sync_word_ff <= reg_wdata_i[SSI_SYNC_W-1:0];
		end
	end

	// control: edge select, sync data enable, sync length
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_ff <= 8'h00;
		end else if (wr_ctrl) begin
			ctrl_ff <= reg_wdata_i[7:0];
		end
	end

	// mask: set register wins over clear register only if both touched, which cannot happen
	// writes to the view index reach neither branch
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mask_ff <= SSI_RESET_ZERO;
		end else if (wr_set) begin
			mask_ff <= mask_ff | (reg_wdata_i & SSI_IRQ_BITS);
		end else if (wr_clr) begin
			mask_ff <= mask_ff & ~reg_wdata_i;
		end
	end

	// count done flags: reaching zero is the falling-into-zero edge
	// a counter write in the same cycle wins, so a reload never shows a stale flag
	wire logic tx_reach = tx_count_zero_i && !tx_zero_q_ff;
	wire logic rx_reach = rx_count_zero_i && !rx_zero_q_ff;

	// zero history resets high so counters idle at zero raise no flag
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_zero_q_ff <= 1'b1;
		end else begin
			tx_zero_q_ff <= tx_count_zero_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_zero_q_ff <= 1'b1;
		end else begin
			rx_zero_q_ff <= rx_count_zero_i;
		end
	end

	// transmit end of count
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_count_done_ff <= 1'b0;
		end else if (tx_count_write_i) begin
			tx_count_done_ff <= 1'b0;
		end else if (tx_reach) begin
			tx_count_done_ff <= 1'b1;
		end
	end

	// receive end of count
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_count_done_ff <= 1'b0;
		end else if (rx_count_write_i) begin
			rx_count_done_ff <= 1'b0;
		end else if (rx_reach) begin
			rx_count_done_ff <= 1'b1;
		end
	end

	// read-cleared flags: a new event in the read cycle survives the read
	// a received word: the load pulse wins over a read of the holding register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_word_available_ff <= 1'b0;
		end else if (rx_holding_load_i) begin
			rx_word_available_ff <= 1'b1;
		end else if (rx_holding_read_i) begin
			rx_word_available_ff <= 1'b0;
		end
	end

	// overflow: a load over an unread word, unless it is read in that same cycle
	wire logic rx_load_over_unread = rx_holding_load_i && rx_word_available_ff && !rx_holding_read_i;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_overflow_ff <= 1'b0;
		end else if (rx_load_over_unread) begin
			rx_overflow_ff <= 1'b1;
		end else if (rd_stat) begin
			rx_overflow_ff <= 1'b0;
		end
	end

	// transmit frame sync, edge chosen by the control register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_fs_seen_ff <= 1'b0;
		end else if (tx_fs_evt) begin
			tx_fs_seen_ff <= 1'b1;
		end else if (rd_stat) begin
			tx_fs_seen_ff <= 1'b0;
		end
	end

	// receive frame sync, reported by the receive engine
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_fs_seen_ff <= 1'b0;
		end else if (rx_sync_event_i) begin
			rx_fs_seen_ff <= 1'b1;
		end else if (rd_stat) begin
			rx_fs_seen_ff <= 1'b0;
		end
	end

	// link pins: two flops before use; only the second stage feeds logic
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fs_sync_ff <= 2'b00;
		end else begin
			fs_sync_ff <= {fs_sync_ff[0], tx_frame_sync_i};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ck_sync_ff <= 2'b00;
		end else begin
			ck_sync_ff <= {ck_sync_ff[0], tx_clk_i};
		end
	end

	// edge history, taken from the second stage
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fs_prev_ff <= 1'b0;
		end else begin
			fs_prev_ff <= fs_s;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ck_prev_ff <= 1'b0;
		end else begin
			ck_prev_ff <= ck_s;
		end
	end

	// sync word shifter: lsb first, one bit per falling transmit clock, sync_length+1 bits
	// the link clock is seen three system clocks late, so it must be several times slower
	wire logic shift_idle = !sd_en || !fs_s;
	wire logic shift_step = ck_fall && bit_cnt_ff <= {1'b0, sync_length};
	wire logic [4:0] nxt_bit_cnt = bit_cnt_ff + 5'h01;
	wire logic tx_sync_bit = tx_sync_word_ff[bit_cnt_ff[3:0]];

	// bit position within the sync word
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bit_cnt_ff <= 5'h00;
		end else if (shift_idle) begin
			bit_cnt_ff <= 5'h00;
		end else if (shift_step) begin
			bit_cnt_ff <= nxt_bit_cnt;
		end
	end

	// data bit, held between link clock edges
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sd_ff <= 1'b0;
		end else if (shift_idle) begin
			sd_ff <= 1'b0;
		end else if (shift_step) begin
			sd_ff <= tx_sync_bit;
		end
	end

	// line is driven from the first bit until frame sync drops or sync data is turned off
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sd_oe_ff <= 1'b0;
		end else if (shift_idle) begin
			sd_oe_ff <= 1'b0;
		end else if (shift_step) begin
			sd_oe_ff <= 1'b1;
		end
	end

	// level interrupt: any pending flag whose mask bit is on
	wire logic [31:0] irq_pending = status & mask_ff & SSI_IRQ_BITS;

	assign reg_rdata_o = rdata_ff;
	assign tx_sync_data_o = sd_ff;
	assign tx_sync_data_oe_o = sd_oe_ff;
	assign irq_o = |irq_pending;
endmodule // ssi_status_irq

`default_nettype wire

// ===== bench/ssi_status_irq_monitor.sv
// port assertions for the serial status block
`timescale 1ns/1ps
`default_nettype none
module ssi_status_irq_monitor
	import ssi_pkg::*;
(
	// clock, reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// watched ports
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic rx_sync_event_i,
	input wire logic transmitter_on_i,
	input wire logic receiver_on_i,
	input wire logic tx_frame_sync_i,
	input wire logic tx_sync_data_oe_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence rd_of(logic [7:0] a);
		$past(reg_rd_i) && $past(reg_addr_i) == a;
	endsequence
	a_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("rdata not zero when idle");
	a_sync_upper: assert property (rd_of(8'h01) |-> reg_rdata_o[31:16] == 16'h0)
		else $error("sync data upper bits set");
	a_enable_bits: assert property (rd_of(8'h02) |-> reg_rdata_o[17:16] == $past({receiver_on_i, transmitter_on_i}))
		else $error("enable bits wrong");
	a_mask_field: assert property (rd_of(8'h05) |-> (reg_rdata_o & ~SSI_IRQ_BITS) == 32'h0)
		else $error("mask has unused bits");
	a_irq_reset: assert property ($past(rst_i) |-> !irq_o)
		else $error("irq high after reset");
	a_oe_quiet: assert property (!tx_frame_sync_i [*6] |=> !tx_sync_data_oe_o)
		else $error("sync data driven outside frame");
	a_mask_clear: assert property (reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i == 32'hffff_ffff |=> !irq_o)
		else $error("irq high with all masked");
	a_rx_sync_read: assert property (rx_sync_event_i ##[1:2] (reg_rd_i && reg_addr_i == 8'h02) |=> reg_rdata_o[11])
		else $error("rx sync flag missing");
	c_irq: cover property (irq_o);
	c_oe: cover property (tx_sync_data_oe_o);
	c_tx_sync: cover property ($past(reg_rd_i) && reg_rdata_o[10]);
endmodule // ssi_status_irq_monitor
`default_nettype wire

// ===== bench/ssi_codec_model.sv
// frame partner: link clock and frame sync, collects sync bits
`timescale 1ns/1ps
`default_nettype none
module ssi_codec_model (
	// control from bench
	input wire logic go_i,
	input wire logic [3:0] nbits_i,
	// line from block
	input wire logic sync_data_i,
	input wire logic sync_oe_i,
	// link pins
	output logic link_clk_o,
	output logic frame_sync_o,
	output logic [15:0] got_o
);
	// clock stands high between frames
	initial begin
		link_clk_o = 1'b1;
		frame_sync_o = 1'b0;
		got_o = 16'h0;
	end
	// undriven line reads inverted so it never matches
	always @(posedge go_i) begin
		got_o = 16'h0;
		frame_sync_o = 1'b1;
		for (int i = 0; i <= nbits_i; i++) begin
			#62.5 link_clk_o = 1'b0;
			#62.5 link_clk_o = 1'b1;
			got_o[i] = sync_oe_i ? sync_data_i : ~sync_data_i;
		end
		#62.5 frame_sync_o = 1'b0;
	end
endmodule // ssi_codec_model
`default_nettype wire

// ===== bench/ssi_status_irq_tb.sv
// self-checking bench for the serial status block
`timescale 1ns/1ps
`default_nettype none
module ssi_status_irq_tb;
	import ssi_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic [31:0] reg_rdata_o, q;
	logic [7:0] lv = 8'h0;
	logic [4:0] pv = 5'h0;
	logic go = 1'b0;
	logic tx_clk_i, tx_frame_sync_i, tx_sync_data_o, tx_sync_data_oe_o, irq_o;
	logic [15:0] got;
	logic [7:0] pat [5] = '{8'h00, 8'hff, 8'h56, 8'ha9, 8'h3e};
	int n_mismatch = 0;
	int total_checks = 0;
	wire logic tx_holding_full_i, tx_shifting_i, tx_count_zero_i, tx_next_count_zero_i, rx_count_zero_i;
	wire logic rx_next_count_zero_i, transmitter_on_i, receiver_on_i, tx_count_write_i, rx_holding_load_i;
	wire logic rx_holding_read_i, rx_count_write_i, rx_sync_event_i;
	assign {receiver_on_i, transmitter_on_i, rx_next_count_zero_i, rx_count_zero_i} = lv[7:4];
	assign {tx_next_count_zero_i, tx_count_zero_i, tx_shifting_i, tx_holding_full_i} = lv[3:0];
	assign {rx_sync_event_i, rx_count_write_i, rx_holding_read_i, rx_holding_load_i, tx_count_write_i} = pv;
	always #5 clk_sys_i = ~clk_sys_i;
	ssi_status_irq ssi_status_irq_i (.*);
	ssi_codec_model ssi_codec_model_i (.go_i(go), .nbits_i(4'h3), .sync_data_i(tx_sync_data_o),
		.sync_oe_i(tx_sync_data_oe_o), .link_clk_o(tx_clk_i), .frame_sync_o(tx_frame_sync_i), .got_o(got));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= w;
		reg_rd_i <= !w;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		#1 q = reg_rdata_o;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("rdata", e, q & m);
	endtask
	task automatic pulse(input logic [4:0] p);
		@(posedge clk_sys_i);
		pv <= p;
		@(posedge clk_sys_i);
		pv <= 5'h0;
		#1;
	endtask
	task automatic setl(input logic [7:0] v);
		@(posedge clk_sys_i);
		lv <= v;
	endtask
	// a frame that never ends is a fault, not a hang
	task automatic wfs(input logic v);
		for (int k = 0; k < 400 && tx_frame_sync_i !== v; k++) @(posedge clk_sys_i);
		if (tx_frame_sync_i !== v) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic frame();
		@(posedge clk_sys_i);
		go <= 1'b1;
		@(posedge clk_sys_i);
		go <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(8'h05, 32'hffff_ffff, 32'h0);
		rdc(8'h02, 32'h0000_0c20, 32'h0);
		bus(1'b1, 8'h00, 32'hffff_a5c3);
		rdc(8'h00, 32'hffff_ffff, 32'h0000_a5c3);
		foreach (pat[i]) begin
			setl(pat[i]);
			rdc(8'h02, 32'h0003_008b, {14'h0, pat[i][7:6], 8'h0, pat[i][5] & pat[i][4], 3'h0,
				pat[i][3] & pat[i][2], 1'b0, ~(pat[i][0] | pat[i][1]), ~pat[i][0]});
		end
		setl(8'h00);
		pulse(5'h09);
		setl(8'h3c);
		rdc(8'h02, 32'h44, 32'h44);
		rdc(8'h02, 32'h44, 32'h44);
		pulse(5'h01);
		rdc(8'h02, 32'h44, 32'h40);
		pulse(5'h08);
		rdc(8'h02, 32'h44, 32'h00);
		pulse(5'h02);
		rdc(8'h02, 32'h30, 32'h10);
		pulse(5'h02);
		rdc(8'h02, 32'h30, 32'h30);
		rdc(8'h02, 32'h30, 32'h10);
		pulse(5'h04);
		rdc(8'h02, 32'h30, 32'h00);
		pulse(5'h10);
		rdc(8'h02, 32'hc00, 32'h800);
		rdc(8'h02, 32'hc00, 32'h000);
		bus(1'b1, 8'h03, 32'hffff_ffff);
		rdc(8'h05, 32'hffff_ffff, SSI_IRQ_BITS);
		bus(1'b1, 8'h05, 32'h0);
		rdc(8'h05, 32'hffff_ffff, SSI_IRQ_BITS);
		chk("irq", 32'h1, {31'h0, irq_o});
		bus(1'b1, 8'h04, 32'hffff_fffe);
		rdc(8'h05, 32'hffff_ffff, 32'h1);
		setl(8'h3d);
		repeat (2) @(posedge clk_sys_i);
		#1 chk("irq", 32'h0, {31'h0, irq_o});
		bus(1'b1, 8'h04, 32'hffff_ffff);
		bus(1'b1, 8'h03, 32'h800);
		pulse(5'h10);
		chk("irq", 32'h1, {31'h0, irq_o});
		rdc(8'h02, 32'h800, 32'h800);
		chk("irq", 32'h0, {31'h0, irq_o});
		bus(1'b1, 8'h07, 32'hffff_ffff);
		rdc(8'h07, 32'hffff_ffff, 32'h0);
		bus(1'b1, 8'h01, 32'h0000_000a);
		bus(1'b1, 8'h06, 32'h32);
		frame();
		wfs(1'b1);
		wfs(1'b0);
		repeat (5) @(posedge clk_sys_i);
		chk("sync", 32'ha, {16'h0, got});
		rdc(8'h02, 32'h400, 32'h400);
		rdc(8'h02, 32'h400, 32'h000);
		bus(1'b1, 8'h06, 32'h33);
		frame();
		repeat (20) @(posedge clk_sys_i);
		rdc(8'h02, 32'h400, 32'h000);
		wfs(1'b0);
		repeat (5) @(posedge clk_sys_i);
		rdc(8'h02, 32'h400, 32'h400);
		report_and_stop();
	end
endmodule // ssi_status_irq_tb
bind ssi_status_irq ssi_status_irq_monitor ssi_status_irq_monitor_i (.*);
`default_nettype wire
